//--- hw/poc_optic_ctrl.sv
//
// Behaviour
// [R1] EEPROM-style two-wire slave link; host starts every transfer.
// [R2] Address 0xA0 selects a 256-byte identification memory.
// [R3] Address 0xA2 selects a 256-byte diagnostics and status memory.
// [R4] Address 0xB0 is reserved for test; host must not rely on it.
// [R5] Diagnostics page gives live temperature, supply, bias, tx, rx power.
// [R6] Transmit-off pin high shuts the transmitter; low allows operation.
// [R7] Undriven transmit-off reads high; transmitter off until driven low.
// [R8] Cycling transmit-off resets the fault state after a fault shutdown.
// [R9] Host leaves at least 10 ms between transmit-off assertions.
// [R10] Byte 110 bit 6 is software transmit-off; bit 7 shows the pin.
// [R11] Transmitter off is software bit OR transmit-off pin.
// [R12] Catastrophic laser fault raises the fault output and turns laser off.
// [R13] Fault output low when normal, high on fault; open collector.
// [R14] Fault latches high; clears only on transmit-off toggle or power cycle.
// [R15] Fault condition mirrored into byte 110 bit 2.
// [R16] Transmit-off and signal-loss flags mirrored into diagnostics memory.
// [R17] Eye-safety monitor forces the transmitter off on unsafe output.
// [R18] Signal-loss output low on adequate input, high when unusable.
// [R19] Signal-loss status mirrored into byte 110 bit 1.
//
`timescale 1ns/1ps
`default_nettype none

module poc_optic_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic twi_scl,
    input wire logic twi_sda_in,
    output logic twi_sda_out,
    output logic twi_sda_oe,
    input wire logic tx_off_pin,
    input wire logic laser_fault_det,
    input wire logic eye_unsafe,
    input wire logic receive_signal_lost,
    input wire logic [15:0] mon_temp,
    input wire logic [15:0] mon_vcc,
    input wire logic [15:0] mon_bias,
    input wire logic [15:0] mon_tx_power,
    input wire logic [15:0] mon_rx_power,
    output logic laser_enable,
    output logic tx_fault_out,
    output logic tx_fault_oe,
    output logic receive_signal_lost_output
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        poc_pkg::poc_twi_st_e st;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic [7:0] ptr;
        logic page;
        logic rd;
        logic ofs_done;
        logic sda_oe;
        logic soft_off;
        logic pin_q;
        logic fault;
        logic laser_en;
        logic fault_oe;
        logic los;
    } poc_state_s;

    poc_state_s q, d;
    logic [7:0] mem [0:511];
    logic we;
    logic [7:0] rd_byte;
    logic [7:0] ctrl_byte;
    logic [15:0] mon [0:poc_pkg::MON_N-1];
    logic pin_fall;
    logic fault_set;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_bit;

    poc_twi_edges u_edges (
        .clk_sys(clk_sys),
        .rst(rst),
        .scl_in(twi_scl),
        .sda_in(twi_sda_in),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen),
        .sda_bit(sda_bit)
    );

    assign mon[0] = mon_temp;
    assign mon[1] = mon_vcc;
    assign mon[2] = mon_bias;
    assign mon[3] = mon_tx_power;
    assign mon[4] = mon_rx_power;

    // ----------------------------------------
    // Status byte and read mux
    // ----------------------------------------
    always_comb begin
        ctrl_byte = poc_pkg::CTRL_RESET;
        ctrl_byte[poc_pkg::BIT_PIN_OFF] = q.pin_q; // R10 R16
        ctrl_byte[poc_pkg::BIT_SOFT_OFF] = q.soft_off; // R10
        ctrl_byte[poc_pkg::BIT_FAULT] = q.fault; // R15
        ctrl_byte[poc_pkg::BIT_LOS] = q.los; // R19 R16
    end

    always_comb begin
        rd_byte = mem[{q.page, q.ptr}];
        if (q.page) begin
            // Live values win over stored bytes, MSB first
            for (int i = 0; i < poc_pkg::MON_N; i++) begin
                if (q.ptr == poc_pkg::OFS_MON + 8'(2 * i)) begin
                    rd_byte = mon[i][15:8]; // R5
                end else if (q.ptr == poc_pkg::OFS_MON + 8'(2 * i + 1)) begin
                    rd_byte = mon[i][7:0]; // R5
                end
            end
            if (q.ptr == poc_pkg::OFS_CTRL) begin
                rd_byte = ctrl_byte; // R16
            end
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    assign pin_fall = q.pin_q & ~tx_off_pin;
    assign fault_set = laser_fault_det | eye_unsafe;

    always_comb begin
        d = q;
        we = 1'b0;

        // Transmitter control
        d.pin_q = tx_off_pin;
        // Set wins over the clearing toggle
        d.fault = fault_set | (q.fault & ~pin_fall); // R8 R14 R12 R17
        d.fault_oe = ~d.fault; // R13
        d.los = receive_signal_lost; // R18
        // Fault and eye-safety act as well, not only the OR pair
        d.laser_en = ~(q.soft_off | tx_off_pin |
            d.fault | eye_unsafe); // R6 R11 R12 R17

        // Two-wire slave, answers only on host clocking
        if (stop_seen) begin
            d.st = poc_pkg::ST_IDLE; // R1
            d.sda_oe = 1'b0;
        end else if (start_seen) begin
            d.st = poc_pkg::ST_ADDR; // R1
            d.cnt = '0;
            d.sda_oe = 1'b0;
            d.ofs_done = 1'b0;
        end else begin
            case (q.st)
                poc_pkg::ST_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                poc_pkg::ST_ADDR, poc_pkg::ST_OFS, poc_pkg::ST_WDATA: begin
                    if (scl_rise && q.cnt < poc_pkg::BYTE_BITS) begin
                        d.shift = {q.shift[6:0], sda_bit};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == poc_pkg::BYTE_BITS) begin
                        d.cnt = '0;
                        if (q.st == poc_pkg::ST_ADDR) begin
                            if (q.shift[7:1] == poc_pkg::DEV_ID || // R2 R3
                                q.shift[7:1] == poc_pkg::DEV_DIAG) begin
                                d.page = (q.shift[7:1] == poc_pkg::DEV_DIAG);
                                d.rd = q.shift[0];
                                d.sda_oe = 1'b1;
                                d.st = poc_pkg::ST_ACK;
                            end else begin
                                // Test page and strangers get no answer
                                d.st = poc_pkg::ST_IDLE; // R4
                            end
                        end else if (q.st == poc_pkg::ST_OFS) begin
                            d.ptr = q.shift;
                            d.ofs_done = 1'b1;
                            d.sda_oe = 1'b1;
                            d.st = poc_pkg::ST_ACK;
                        end else begin
                            we = 1'b1;
                            if (q.page && q.ptr == poc_pkg::OFS_CTRL) begin
                                d.soft_off =
                                    q.shift[poc_pkg::BIT_SOFT_OFF]; // R10
                            end
                            d.ptr = q.ptr + 8'h01;
                            d.sda_oe = 1'b1;
                            d.st = poc_pkg::ST_ACK;
                        end
                    end
                end
                poc_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.cnt = '0;
                        if (q.rd) begin
                            d.shift = rd_byte;
                            d.ptr = q.ptr + 8'h01;
                            d.sda_oe = ~rd_byte[7];
                            d.st = poc_pkg::ST_RDATA;
                        end else if (q.ofs_done) begin
                            d.st = poc_pkg::ST_WDATA;
                        end else begin
                            d.st = poc_pkg::ST_OFS;
                        end
                    end
                end
                poc_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt == poc_pkg::LAST_BIT) begin
                            d.sda_oe = 1'b0;
                            d.st = poc_pkg::ST_RACK;
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.sda_oe = ~q.shift[6];
                        end
                    end
                end
                poc_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        // A not-acknowledge ends the read until the next start
                        if (sda_bit) begin
                            d.st = poc_pkg::ST_IDLE;
                        end else begin
                            d.st = poc_pkg::ST_ACK;
                        end
                    end
                end
                default: begin
                    d.st = poc_pkg::ST_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q.st <= poc_pkg::ST_IDLE;
            q.shift <= '0;
            q.cnt <= '0;
            q.ptr <= '0;
            q.page <= 1'b0;
            q.rd <= 1'b0;
            q.ofs_done <= 1'b0;
            q.sda_oe <= 1'b0;
            q.soft_off <= 1'b0;
            // Pin taken as high until seen low
            q.pin_q <= 1'b1; // R7
            q.fault <= 1'b0;
            q.laser_en <= 1'b0; // R7
            q.fault_oe <= 1'b1;
            q.los <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // No reset: contents behave like the nonvolatile array
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[{q.page, q.ptr}] <= q.shift; // R2 R3
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign twi_sda_out = 1'b0;
    assign twi_sda_oe = q.sda_oe;
    assign laser_enable = q.laser_en;
    assign tx_fault_out = 1'b0;
    assign tx_fault_oe = q.fault_oe; // R13
    assign receive_signal_lost_output = q.los; // R18

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_addr_byte(logic [6:0] dev);
        q.st == poc_pkg::ST_ADDR && scl_fall && !start_seen && !stop_seen &&
            q.cnt == poc_pkg::BYTE_BITS && q.shift[7:1] == dev;
    endsequence

    a_test_page_silent: assert property ( // R4
        s_addr_byte(poc_pkg::DEV_TEST) |=>
            !q.sda_oe && q.st == poc_pkg::ST_IDLE)
        else $error("test page address was acknowledged");

    a_id_page_ack: assert property ( // R2
        s_addr_byte(poc_pkg::DEV_ID) |=> q.sda_oe && !q.page)
        else $error("identification address not acknowledged");

    a_diag_page_ack: assert property ( // R3
        s_addr_byte(poc_pkg::DEV_DIAG) |=> q.sda_oe && q.page)
        else $error("diagnostics address not acknowledged");

    a_read_first_bit: assert property ( // R1
        q.st == poc_pkg::ST_ACK && scl_fall && q.rd &&
            !start_seen && !stop_seen
            |=> q.st == poc_pkg::ST_RDATA && q.sda_oe == ~q.shift[7])
        else $error("read byte not driven after acknowledge");

    a_pin_off: assert property ( // R6
        tx_off_pin |=> !laser_enable)
        else $error("transmitter on while off pin high");

    a_reset_off: assert property ( // R7
        $fell(rst) |-> !laser_enable && q.pin_q)
        else $error("transmitter not off after reset");

    a_soft_off: assert property ( // R11
        q.soft_off |=> !laser_enable)
        else $error("software off request ignored");

    a_fault_sets: assert property ( // R12
        laser_fault_det |=> q.fault && !laser_enable && !tx_fault_oe)
        else $error("laser fault not latched");

    a_fault_holds: assert property ( // R14
        q.fault && !pin_fall |=> q.fault)
        else $error("fault cleared without toggle");

    a_fault_clears: assert property ( // R8
        q.fault && pin_fall && !fault_set |=> !q.fault && tx_fault_oe)
        else $error("toggle did not clear fault");

    a_eye_off: assert property ( // R17
        eye_unsafe |=> !laser_enable ##0 q.fault)
        else $error("eye safety did not force off");

    a_status_mirror: assert property ( // R15
        q.page && q.ptr == poc_pkg::OFS_CTRL |->
            rd_byte[poc_pkg::BIT_FAULT] == q.fault &&
            rd_byte[poc_pkg::BIT_LOS] == q.los &&
            rd_byte[poc_pkg::BIT_PIN_OFF] == q.pin_q)
        else $error("status byte does not mirror flags");

    a_los_follow: assert property ( // R18
        receive_signal_lost |=> receive_signal_lost_output)
        else $error("signal loss output not raised");

endmodule // poc_optic_ctrl

`default_nettype wire

//--- hw/poc_pkg.sv
package poc_pkg;

    // ----------------------------------------
    // Two-wire device addresses (7-bit form)
    // ----------------------------------------
    localparam logic [6:0] DEV_ID = 7'h50;
    localparam logic [6:0] DEV_DIAG = 7'h51;
    localparam logic [6:0] DEV_TEST = 7'h58;

    // ----------------------------------------
    // Diagnostics page layout
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h6e;
    localparam int BIT_PIN_OFF = 7;
    localparam int BIT_SOFT_OFF = 6;
    localparam int BIT_FAULT = 2;
    localparam int BIT_LOS = 1;
    localparam logic [7:0] OFS_MON = 8'h60;
    localparam int MON_N = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ----------------------------------------
    // Framing and timing
    // ----------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam int TX_OFF_GAP_MS = 10;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_OFS,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK
    } poc_twi_st_e;

endpackage

//--- hw/poc_twi_edges.sv
`timescale 1ns/1ps
`default_nettype none

module poc_twi_edges (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen,
    output logic sda_bit
);

    // ----------------------------------------
    // Previous line levels
    // ----------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } poc_edge_s;

    poc_edge_s q, d;

    always_comb begin
        d.scl = scl_in;
        d.sda = sda_in;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            q <= d;
        end
    end

    // Data only moves while the clock is low, so sda edges
    // with the clock high are framing markers
    assign scl_rise = scl_in & ~q.scl;
    assign scl_fall = ~scl_in & q.scl;
    assign start_seen = scl_in & q.scl & q.sda & ~sda_in;
    assign stop_seen = scl_in & q.scl & ~q.sda & sda_in;
    assign sda_bit = sda_in;

endmodule // poc_twi_edges

`default_nettype wire

//--- sim/poc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module poc_host_model (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull,
    output logic tx_off_drv,
    output logic tx_off_en,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    // ----------------------------------------
    // Host board side of link and pins
    // ----------------------------------------
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        tx_off_drv = 1'b0;
        tx_off_en = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Data moves only while clock low
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        tick(3);
        scl = 1'b1;
        tick(2);
        r = sda_line;
        tick(2);
        scl = 1'b0;
        tick(1);
    endtask

    // Host opens every transfer; also a repeated start
    task automatic start_c();
        sda_pull = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(1);
    endtask

    task automatic stop_c();
        sda_pull = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b0;
        tick(4);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, nak);
    endtask

    task automatic recv_byte(input logic last);
        logic r;
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(last, r);
        rd_data = v;
        rd_valid = 1'b1;
        tick(1);
        rd_valid = 1'b0;
    endtask

    task automatic write_one(input logic [7:0] dev, input logic [7:0] ofs,
        input logic [7:0] d, output logic nak);
        logic a, b, c;
        start_c();
        send_byte(dev, a);
        send_byte(ofs, b);
        send_byte(d, c);
        stop_c();
        nak = a | b | c;
    endtask

    // Random read: offset write, repeated start, n bytes
    task automatic read_seq(input logic [7:0] dev, input logic [7:0] ofs,
        input int n, output logic nak);
        logic a, b, c;
        start_c();
        send_byte(dev, a);
        send_byte(ofs, b);
        start_c();
        send_byte(dev | 8'h01, c);
        for (int k = 0; k < n; k++) recv_byte(k == n - 1);
        stop_c();
        nak = a | b | c;
    endtask

    // Reserved page is only probed, never used
    task automatic probe(input logic [7:0] dev, output logic nak);
        start_c();
        send_byte(dev, nak);
        stop_c();
    endtask

    // Gap kept short to fit the run; the block does not police it
    task automatic set_pin(input logic v);
        tx_off_en = 1'b1;
        tx_off_drv = v;
        tick(4);
    endtask
endmodule // poc_host_model

`default_nettype wire

//--- sim/poc_optic_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("mismatch %s expected %h seen %h", nm, e, g); \
        end \
    end

module poc_optic_ctrl_tb_top;
    localparam logic [7:0] ID_W = {poc_pkg::DEV_ID, 1'b0};
    localparam logic [7:0] DIAG_W = {poc_pkg::DEV_DIAG, 1'b0};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_pull, sda_line, tx_off_drv, tx_off_en, tx_off_pin;
    logic laser_fault_det, eye_unsafe, receive_signal_lost;
    logic rd_valid, nak, laser_enable, fault_line, rsl_out;
    logic twi_sda_out, twi_sda_oe, tx_fault_out, tx_fault_oe;
    logic [7:0] rd_data, e_b;
    logic [15:0] mon_v [0:4];
    logic [15:0] rnd = 16'h9715;
    logic [7:0] exp_q [$];
    int num_errors = 0;
    int num_checks = 0;

    always #4 clk_sys = ~clk_sys;
    // Pull-ups on data, transmit-off and fault lines
    assign sda_line = ~(sda_pull | (twi_sda_oe & ~twi_sda_out));
    assign tx_off_pin = tx_off_en ? tx_off_drv : 1'b1;
    assign fault_line = tx_fault_oe ? tx_fault_out : 1'b1;

    poc_optic_ctrl u_poc_optic_ctrl (
        .clk_sys(clk_sys), .rst(rst), .twi_scl(scl),
        .twi_sda_in(sda_line), .twi_sda_out(twi_sda_out),
        .twi_sda_oe(twi_sda_oe), .tx_off_pin(tx_off_pin),
        .laser_fault_det(laser_fault_det), .eye_unsafe(eye_unsafe),
        .receive_signal_lost(receive_signal_lost),
        .mon_temp(mon_v[0]), .mon_vcc(mon_v[1]), .mon_bias(mon_v[2]),
        .mon_tx_power(mon_v[3]), .mon_rx_power(mon_v[4]),
        .laser_enable(laser_enable), .tx_fault_out(tx_fault_out),
        .tx_fault_oe(tx_fault_oe), .receive_signal_lost_output(rsl_out)
    );

    poc_host_model u_poc_host_model (
        .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull), .tx_off_drv(tx_off_drv),
        .tx_off_en(tx_off_en), .rd_valid(rd_valid), .rd_data(rd_data)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic wait_clk(input int n);
        u_poc_host_model.tick(n);
    endtask

    task automatic wr(input logic [7:0] dev, ofs, d);
        u_poc_host_model.write_one(dev, ofs, d, nak);
        `CHK("write_ack", 1'b0, nak)
    endtask

    task automatic rd(input logic [7:0] dev, ofs, e);
        exp_q.push_back(e);
        u_poc_host_model.read_seq(dev, ofs, 1, nak);
        `CHK("read_ack", 1'b0, nak)
    endtask

    task automatic test_end(input string s);
        $display("test %s done", s);
    endtask

    task automatic test_done();
        `CHK("queue_left", 0, exp_q.size())
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Oldest note against each byte the host reads back
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            e_b = (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data;
            `CHK("read_byte", e_b, rd_data)
        end
    end

    initial begin
        repeat (50000) @(posedge clk_sys);
        num_errors++;
        test_done();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [7:0] o, d;
        laser_fault_det = 1'b0;
        eye_unsafe = 1'b0;
        receive_signal_lost = 1'b0;
        for (int k = 0; k < 5; k++) mon_v[k] = 16'h0000;
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        wait_clk(2);
        `CHK("laser_enable", 1'b0, laser_enable)
        `CHK("fault_line", 1'b0, fault_line)
        rd(DIAG_W, poc_pkg::OFS_CTRL, 8'h80);
        test_end("reset");
        u_poc_host_model.set_pin(1'b0);
        `CHK("laser_enable", 1'b1, laser_enable)
        rd(DIAG_W, poc_pkg::OFS_CTRL, 8'h00);
        u_poc_host_model.set_pin(1'b1);
        `CHK("laser_enable", 1'b0, laser_enable)
        u_poc_host_model.set_pin(1'b0);
        test_end("pin");
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            o = (k == 0) ? 8'hff : {2'b00, rnd[5:0]};
            d = rnd[15:8];
            wr(ID_W, o, d);
            wr(DIAG_W, o, ~d);
            rd(ID_W, o, d);
            rd(DIAG_W, o, ~d);
        end
        test_end("pages");
        u_poc_host_model.probe(8'hb0, nak);
        `CHK("reserved_nak", 1'b1, nak)
        u_poc_host_model.probe(8'hb1, nak);
        `CHK("reserved_nak", 1'b1, nak)
        test_end("reserved");
        for (int k = 0; k < 5; k++) begin
            rnd = lfsr(rnd);
            mon_v[k] = rnd;
            exp_q.push_back(rnd[15:8]);
            exp_q.push_back(rnd[7:0]);
        end
        u_poc_host_model.read_seq(DIAG_W, poc_pkg::OFS_MON, 10, nak);
        `CHK("mon_ack", 1'b0, nak)
        test_end("monitor");
        wr(DIAG_W, poc_pkg::OFS_CTRL, 8'hff);
        `CHK("laser_enable", 1'b0, laser_enable)
        rd(DIAG_W, poc_pkg::OFS_CTRL, 8'h40);
        wr(DIAG_W, poc_pkg::OFS_CTRL, 8'h00);
        `CHK("laser_enable", 1'b1, laser_enable)
        test_end("soft_off");
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            receive_signal_lost = rnd[k];
            wait_clk(2);
            `CHK("los_out", rnd[k], rsl_out)
        end
        receive_signal_lost = 1'b1;
        wait_clk(2);
        `CHK("los_out", 1'b1, rsl_out)
        rd(DIAG_W, poc_pkg::OFS_CTRL, 8'h02);
        receive_signal_lost = 1'b0;
        wait_clk(2);
        `CHK("los_out", 1'b0, rsl_out)
        test_end("los");
        // One of two cycles carries the fault, which one is random
        rnd = lfsr(rnd);
        laser_fault_det = rnd[0];
        wait_clk(1);
        laser_fault_det = ~rnd[0];
        wait_clk(1);
        laser_fault_det = 1'b0;
        wait_clk(2);
        `CHK("laser_enable", 1'b0, laser_enable)
        `CHK("fault_line", 1'b1, fault_line)
        rd(DIAG_W, poc_pkg::OFS_CTRL, 8'h04);
        u_poc_host_model.set_pin(1'b1);
        `CHK("fault_line", 1'b1, fault_line)
        rd(DIAG_W, poc_pkg::OFS_CTRL, 8'h84);
        u_poc_host_model.set_pin(1'b0);
        `CHK("fault_line", 1'b0, fault_line)
        `CHK("laser_enable", 1'b1, laser_enable)
        test_end("fault");
        eye_unsafe = rnd[1];
        wait_clk(1);
        eye_unsafe = ~rnd[1];
        wait_clk(1);
        `CHK("laser_enable", 1'b0, laser_enable)
        eye_unsafe = 1'b0;
        wait_clk(2);
        `CHK("fault_line", 1'b1, fault_line)
        u_poc_host_model.set_pin(1'b1);
        u_poc_host_model.set_pin(1'b0);
        `CHK("laser_enable", 1'b1, laser_enable)
        test_end("eye_safety");
        test_done();
    end
endmodule // poc_optic_ctrl_tb_top

`default_nettype wire
